//--- core/quad_phase_fetch_pipeline.sv
// Two-stage fetch/execute sequencer with quadrature phase scheduling.
// Assumes program and data memories answer combinationally in the same cycle.
// How it works
// RULE_01 - Divide clock by four into phases
// RULE_02 - Increment pointer in phase one
// RULE_03 - Latch fetched word in phase four
// RULE_04 - Overlap fetch with execute, one per cycle
// RULE_05 - Present word phase one, execute phases two-four
// RULE_06 - Read operand phase two, write phase four
// RULE_07 - Branch flushes fetched word, two cycles
// RULE_08 - Thirteen-bit pointer, 8K by 14 space
// RULE_09 - Implement only low program space per variant
// RULE_10 - Addresses beyond boundary wrap around
// RULE_11 - Start fetching at address zero after reset
// RULE_12 - Interrupt goes to address four
// RULE_13 - Bank select bit five chooses bank
// RULE_14 - Special registers in lowest 32 locations
// RULE_15 - General RAM ranges per variant
// RULE_16 - Cycle clock out at quarter rate
// RULE_17 - Held in reset while clear low
// RULE_18 - Drop pointer bits above implemented width
// RULE_19 - Reset restarts divider and flushes pipeline
`timescale 1ns/1ps
`default_nettype none
module quad_phase_fetch_pipeline
    import fetch_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   master_clear_n,
    input  wire logic [WORD_W-1:0]      prog_data,
    input  wire logic                   branch_req,
    input  wire logic [FETCH_PTR_W-1:0] branch_target,
    input  wire logic                   irq_req,
    input  wire logic [7:0]             status_reg,
    input  wire logic [DATA_ADDR_W-1:0] data_addr,
    input  wire logic                   data_write_req,
    output logic [FETCH_PTR_W-1:0]      prog_addr,
    output logic [FETCH_PTR_W-1:0]      fetch_pointer,
    output logic [WORD_W-1:0]           instruction_latch,
    output logic                        exec_valid,
    output logic [BANK_ADDR_W-1:0]      data_bank_addr,
    output logic                        data_read_en,
    output logic                        data_write_en,
    output logic                        special_register_area,
    output logic                        general_ram_area,
    output logic                        cycle_clock_out,
    output logic [3:0]                  phase_out
);
    localparam int unsigned IMPL_W = LARGE_VARIANT ? LARGE_IMPL_W : SMALL_IMPL_W; // RULE_09

    function automatic logic [FETCH_PTR_W-1:0] wrap_addr(input logic [FETCH_PTR_W-1:0] a);
        logic [FETCH_PTR_W-1:0] mask;
        mask = FETCH_PTR_W'((1 << IMPL_W) - 1);
        return a & mask; // RULE_18
    endfunction : wrap_addr

    function automatic region_type classify(input logic [7:0] a);
        region_type r;
        r = REGION_NONE;
        if (a[6:0] <= SPECIAL_TOP[6:0]) begin
            r = REGION_SPECIAL; // RULE_14
        end else if (!a[7] && a >= RAM0_LO
                     && a <= (LARGE_VARIANT ? RAM0_HI_LARGE : RAM0_HI_SMALL)) begin
            r = REGION_RAM; // RULE_15
        end else if (LARGE_VARIANT && a >= RAM1_LO && a <= RAM1_HI) begin
            r = REGION_RAM; // RULE_15
        end
        return r;
    endfunction : classify

    // Master clear comes from a pin, so it is synchronised before use.
    logic clr_meta_q;
    logic clr_sync_q;
    logic hold_rst;

    always_ff @(posedge mclk) begin
        if (rst) begin
            clr_meta_q <= 1'b0;
            clr_sync_q <= 1'b0;
        end else begin
            clr_meta_q <= master_clear_n;
            clr_sync_q <= clr_meta_q;
        end
    end
    assign hold_rst = rst || !clr_sync_q; // RULE_17

    phase_if ph ();
    phase_divider u_div (
        .mclk (mclk),
        .rst  (hold_rst),
        .ph   (ph)
    );

    logic [FETCH_PTR_W-1:0] fetch_q;
    logic [WORD_W-1:0]      fetched_q;
    logic                   fetched_ok_q;
    logic                   redirect_q;
    logic [FETCH_PTR_W-1:0] redirect_addr_q;

    // A branch or interrupt seen during execution replaces the next fetch.
    always_ff @(posedge mclk) begin
        if (hold_rst) begin
            redirect_q      <= 1'b0;
            redirect_addr_q <= RESET_VECTOR;
        end else if (ph.phase_strobe[3] && irq_req) begin
            redirect_q      <= 1'b1;
            redirect_addr_q <= IRQ_VECTOR; // RULE_12
        end else if (ph.phase_strobe[3] && branch_req && exec_valid) begin
            redirect_q      <= 1'b1;
            redirect_addr_q <= branch_target; // RULE_07
        end else if (ph.phase_strobe[0]) begin
            redirect_q      <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (hold_rst) begin
            fetch_q   <= RESET_VECTOR; // RULE_11
            prog_addr <= RESET_VECTOR;
        end else if (ph.phase_strobe[0]) begin
            prog_addr <= wrap_addr(redirect_q ? redirect_addr_q : fetch_q); // RULE_10
            fetch_q   <= wrap_addr((redirect_q ? redirect_addr_q : fetch_q) + 13'h0001); // RULE_02
        end
    end
    assign fetch_pointer = fetch_q; // RULE_08

    always_ff @(posedge mclk) begin
        if (hold_rst) begin
            fetched_q    <= NOP_WORD;
            fetched_ok_q <= 1'b0; // RULE_19
        end else if (ph.phase_strobe[3]) begin
            fetched_q    <= prog_data; // RULE_03
            fetched_ok_q <= !(irq_req || (branch_req && exec_valid)); // RULE_07
        end
    end

    always_ff @(posedge mclk) begin
        if (hold_rst) begin
            instruction_latch <= NOP_WORD;
            exec_valid        <= 1'b0;
        end else if (ph.phase_strobe[0]) begin
            instruction_latch <= fetched_q; // RULE_05
            exec_valid        <= fetched_ok_q; // RULE_04
        end
    end

    logic [7:0] bank_addr;
    assign bank_addr = {status_reg[BANK_SELECT_POS], data_addr}; // RULE_13

    always_ff @(posedge mclk) begin
        if (hold_rst) begin
            data_bank_addr        <= 8'h00;
            data_read_en          <= 1'b0;
            data_write_en         <= 1'b0;
            special_register_area <= 1'b0;
            general_ram_area      <= 1'b0;
        end else begin
            data_bank_addr        <= bank_addr;
            data_read_en          <= exec_valid && ph.phase_strobe[1]; // RULE_06
            data_write_en         <= exec_valid && ph.phase_strobe[3] && data_write_req; // RULE_06
            special_register_area <= classify(bank_addr) == REGION_SPECIAL;
            general_ram_area      <= classify(bank_addr) == REGION_RAM;
        end
    end

    always_ff @(posedge mclk) begin
        if (hold_rst) begin
            cycle_clock_out <= 1'b0;
            phase_out       <= 4'h0;
        end else begin
            cycle_clock_out <= ph.phase_strobe[1] || ph.phase_strobe[2]; // RULE_16
            phase_out       <= ph.phase_strobe;
        end
    end

    a_fetch_step : assert property (@(posedge mclk) disable iff (hold_rst)
        ph.phase_strobe[0] && !redirect_q |=> fetch_q == wrap_addr($past(fetch_q) + 13'h0001)) // RULE_02
        else $error("Fetch pointer did not step in phase one.");
    a_ptr_wrap : assert property (@(posedge mclk) disable iff (hold_rst)
        (fetch_q >> IMPL_W) == 13'h0000) // RULE_10
        else $error("Fetch pointer left implemented space.");
    a_read_phase : assert property (@(posedge mclk) disable iff (hold_rst)
        data_read_en |-> $past(ph.phase_strobe[1])) // RULE_06
        else $error("Operand read outside phase two.");
    a_write_phase : assert property (@(posedge mclk) disable iff (hold_rst)
        data_write_en |-> $past(ph.phase_strobe[3])) // RULE_06
        else $error("Result write outside phase four.");
    a_irq_vector : assert property (@(posedge mclk) disable iff (hold_rst)
        ph.phase_strobe[3] && irq_req |=> ##1 prog_addr == IRQ_VECTOR) // RULE_12
        else $error("Interrupt did not fetch from vector.");
    a_branch_flush : assert property (@(posedge mclk) disable iff (hold_rst)
        ph.phase_strobe[3] && branch_req && exec_valid |=> ##1 !exec_valid) // RULE_07
        else $error("Branch did not flush fetched word.");
    a_latch_load : assert property (@(posedge mclk) disable iff (hold_rst)
        ph.phase_strobe[0] |=> instruction_latch == $past(fetched_q)) // RULE_05
        else $error("Instruction latch not loaded in phase one.");
    a_bank_select : assert property (@(posedge mclk) disable iff (hold_rst)
        !hold_rst |=> data_bank_addr[7] == $past(status_reg[BANK_SELECT_POS])) // RULE_13
        else $error("Bank select bit not honoured.");
    a_cycle_clock_out_rate : assert property (@(posedge mclk) disable iff (hold_rst)
        $rose(cycle_clock_out) |=> cycle_clock_out ##1 !cycle_clock_out ##1 !cycle_clock_out
        ##1 cycle_clock_out) // RULE_16
        else $error("Cycle clock out not a quarter rate.");
endmodule : quad_phase_fetch_pipeline
`default_nettype wire

//--- core/fetch_pkg.sv
// Shared constants and types for the quadrature-phase fetch pipeline.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
package fetch_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned PHASE_COUNT     = 4;
    localparam int unsigned FETCH_PTR_W     = 13;
    localparam int unsigned WORD_W          = 14;
    localparam int unsigned DATA_ADDR_W     = 7;
    localparam int unsigned BANK_ADDR_W     = 8;
    localparam int unsigned SMALL_IMPL_W    = 9;
    localparam int unsigned LARGE_IMPL_W    = 11;
    localparam logic [12:0] RESET_VECTOR    = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR      = 13'h0004;
    localparam int unsigned BANK_SELECT_POS = 5;
    localparam logic [7:0]  SPECIAL_TOP     = 8'h1F;
    localparam logic [7:0]  RAM0_LO         = 8'h20;
    localparam logic [7:0]  RAM0_HI_SMALL   = 8'h6F;
    localparam logic [7:0]  RAM0_HI_LARGE   = 8'h7F;
    localparam logic [7:0]  RAM1_LO         = 8'hA0;
    localparam logic [7:0]  RAM1_HI         = 8'hBF;
    localparam logic [1:0]  PHASE_RESET     = 2'h0;
    localparam logic [13:0] NOP_WORD        = 14'h0000;

    typedef enum logic [1:0] {
        REGION_SPECIAL,
        REGION_RAM,
        REGION_NONE
    } region_type;
endpackage : fetch_pkg

//--- core/phase_if.sv
// Phase strobes shared between the phase divider and the pipeline.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface phase_if;
    logic [3:0] phase_strobe;
    logic       cycle_start;
    modport source (output phase_strobe, output cycle_start);
    modport sink   (input phase_strobe, input cycle_start);
endinterface : phase_if
`default_nettype wire

//--- core/phase_divider.sv
// Divides the clock by four into one-hot phase strobes.
// Assumes a synchronous active-high reset that restarts at phase one.
`timescale 1ns/1ps
`default_nettype none
module phase_divider
    import fetch_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    phase_if.source   ph
);
    logic [1:0] count_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            count_q <= PHASE_RESET; // RULE_19
        end else begin
            count_q <= count_q + 2'h1; // RULE_01
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_strobe
            assign ph.phase_strobe[g] = !rst && (count_q == 2'(g));
        end
    endgenerate
    assign ph.cycle_start = ph.phase_strobe[0];

    a_strobe_onehot : assert property (@(posedge mclk) disable iff (rst)
        !rst |-> $onehot(ph.phase_strobe)) // RULE_01
        else $error("Phase strobes are not one-hot.");
endmodule : phase_divider
`default_nettype wire

//--- dv/prog_mem_model.sv
// Program memory seen by the fetch pipeline: each word is its address with a marker bit.
// Assumes a combinational answer to the fetch address in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
    import fetch_pkg::*;
(
    input  wire logic [FETCH_PTR_W-1:0] prog_addr,
    output logic [WORD_W-1:0]           prog_data
);
    // The marker bit keeps a fetched word from ever looking like the all-zero NOP_WORD that reset loads.
    assign prog_data = {1'b1, prog_addr};
endmodule : prog_mem_model
`default_nettype wire

//--- dv/tb_quad_phase_fetch_pipeline.sv
// Self-checking bench for the quadrature-phase fetch pipeline, large and small variants.
// Assumes the program memory model and a 50 MHz clock made here.
`timescale 1ns/1ps
`default_nettype none
module tb_quad_phase_fetch_pipeline;
    import fetch_pkg::*;
    logic mclk, rst, master_clear_n, branch_req, irq_req, data_write_req;
    logic [WORD_W-1:0] prog_data, instruction_latch;
    logic [12:0] branch_target, prog_addr, fetch_pointer;
    logic [7:0] status_reg, data_bank_addr;
    logic [6:0] data_addr;
    logic exec_valid, data_read_en, data_write_en, special_register_area, general_ram_area;
    logic cycle_clock_out;
    logic [3:0] phase_out;
    logic [WORD_W-1:0] prog_data_s;
    logic [12:0] prog_addr_s;
    logic general_ram_area_s;
    int n_mismatch, n_compared, cycles;

    quad_phase_fetch_pipeline #(.LARGE_VARIANT(1'b1)) dut_u (.mclk(mclk), .rst(rst),
        .master_clear_n(master_clear_n), .prog_data(prog_data), .branch_req(branch_req),
        .branch_target(branch_target), .irq_req(irq_req), .status_reg(status_reg),
        .data_addr(data_addr), .data_write_req(data_write_req), .prog_addr(prog_addr),
        .fetch_pointer(fetch_pointer), .instruction_latch(instruction_latch),
        .exec_valid(exec_valid), .data_bank_addr(data_bank_addr),
        .data_read_en(data_read_en), .data_write_en(data_write_en),
        .special_register_area(special_register_area), .general_ram_area(general_ram_area),
        .cycle_clock_out(cycle_clock_out), .phase_out(phase_out));
    prog_mem_model mem_u (.prog_addr(prog_addr), .prog_data(prog_data));

    // The small variant runs beside the large one to check its narrower space and RAM map.
    quad_phase_fetch_pipeline #(.LARGE_VARIANT(1'b0)) dut_small_u (.mclk(mclk), .rst(rst),
        .master_clear_n(master_clear_n), .prog_data(prog_data_s), .branch_req(branch_req),
        .branch_target(branch_target), .irq_req(irq_req), .status_reg(status_reg),
        .data_addr(data_addr), .data_write_req(data_write_req), .prog_addr(prog_addr_s),
        .fetch_pointer(), .instruction_latch(), .exec_valid(), .data_bank_addr(),
        .data_read_en(), .data_write_en(), .special_register_area(),
        .general_ram_area(general_ram_area_s), .cycle_clock_out(), .phase_out());
    prog_mem_model mem_small_u (.prog_addr(prog_addr_s), .prog_data(prog_data_s));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic summarize();
        if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    // The ceiling is more than thirty times the length of the whole sequence.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    // Advances to the next clock at which phase one is shown.
    task automatic next_cycle();
        tick(1);
        for (int i = 0; i < 8 && phase_out !== 4'h1; i++) tick(1);
    endtask : next_cycle

    task automatic t_reset();
        int highs;
        rst = 1'b1;
        tick(3);
        chk("prog_addr in reset", 16'h0000, prog_addr);
        chk("phase in reset", 16'h0000, phase_out);
        rst = 1'b0;
        next_cycle();
        highs = 0;
        for (int i = 0; i < 8; i++) begin
            chk("phase_out", 16'(4'h1 << (i % 4)), phase_out);
            highs += (cycle_clock_out === 1'b1);
            tick(1);
        end
        chk("cycle_clock_out highs", 16'h0004, 16'(highs));
    endtask : t_reset

    task automatic t_sequence();
        rst = 1'b1;
        tick(3);
        rst = 1'b0;
        next_cycle();
        for (int k = 0; k < 6; k++) begin
            chk("prog_addr", 16'(k), prog_addr);
            chk("fetch_pointer", 16'(k + 1), 16'(fetch_pointer));
            if (k > 1) chk("latch", 16'({1'b1, 13'(k - 1)}), instruction_latch);
            if (k > 1) chk("exec_valid", 16'h0001, exec_valid);
            next_cycle();
        end
    endtask : t_sequence

    // The redirect address stands only in the first cycle after the deciding phase four.
    task automatic t_redirect(input logic irq, input logic [12:0] tgt, input logic [12:0] exp,
                              input logic [12:0] exp_small);
        branch_req = ~irq;
        irq_req = irq;
        branch_target = tgt;
        next_cycle();
        branch_req = 1'b0;
        irq_req = 1'b0;
        chk("redirect addr", 16'(exp), 16'(prog_addr));
        chk("flushed word", 16'h0000, 16'(exec_valid));
        chk("pointer after redirect", 16'(exp + 13'h0001), 16'(fetch_pointer));
        chk("small redirect addr", 16'(exp_small), 16'(prog_addr_s));
        next_cycle();
        chk("addr after redirect", 16'(exp + 13'h0001), prog_addr);
        chk("target latched", 16'({1'b1, exp}), 16'(instruction_latch));
    endtask : t_redirect

    task automatic t_data(input logic bank, input logic [6:0] a, input logic [7:0] exp,
                          input logic spec, input logic ram, input logic ram_small,
                          input logic wreq);
        int rd;
        int wr;
        rd = 0;
        wr = 0;
        status_reg = {2'h0, bank, 5'h00};
        data_addr = a;
        data_write_req = wreq;
        next_cycle();
        next_cycle();
        for (int i = 0; i < 4; i++) begin
            rd += (data_read_en === 1'b1);
            wr += (data_write_en === 1'b1);
            tick(1);
        end
        chk("bank addr", 16'(exp), data_bank_addr);
        chk("special area", 16'(spec), special_register_area);
        chk("ram area", 16'(ram), general_ram_area);
        chk("small ram area", 16'(ram_small), 16'(general_ram_area_s));
        chk("reads per cycle", 16'h0001, 16'(rd));
        chk("writes per cycle", 16'(wreq), 16'(wr));
    endtask : t_data

    task automatic t_clear();
        master_clear_n = 1'b0;
        tick(8);
        chk("addr in clear", 16'h0000, prog_addr);
        chk("valid in clear", 16'h0000, exec_valid);
        master_clear_n = 1'b1;
        next_cycle();
        chk("addr after clear", 16'h0000, prog_addr);
        next_cycle();
        chk("second fetch after clear", 16'h0001, prog_addr);
    endtask : t_clear

    initial begin
        {branch_req, irq_req, data_write_req} = 3'h0;
        master_clear_n = 1'b1;
        branch_target = 13'h0000;
        status_reg = 8'h00;
        data_addr = 7'h00;
        n_mismatch = 0;
        n_compared = 0;
        t_reset();
        t_sequence();
        t_redirect(1'b0, 13'h1FF5, 13'h07F5, 13'h01F5);
        t_redirect(1'b0, 13'h0123, 13'h0123, 13'h0123);
        t_redirect(1'b1, 13'h0456, IRQ_VECTOR, IRQ_VECTOR);
        t_data(1'b0, 7'h05, 8'h05, 1'b1, 1'b0, 1'b0, 1'b1);
        t_data(1'b1, 7'h20, 8'hA0, 1'b0, 1'b1, 1'b0, 1'b1);
        t_data(1'b0, 7'h7F, 8'h7F, 1'b0, 1'b1, 1'b0, 1'b1);
        t_data(1'b0, 7'h6F, 8'h6F, 1'b0, 1'b1, 1'b1, 1'b1);
        t_data(1'b1, 7'h40, 8'hC0, 1'b0, 1'b0, 1'b0, 1'b0);
        t_clear();
        summarize();
    end
endmodule : tb_quad_phase_fetch_pipeline
`default_nettype wire
